/* File: logic_branch_exec_consts.vh */
`ifndef LOGIC_BRANCH_EXEC_CONSTS_VH
`define LOGIC_BRANCH_EXEC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define OFF_CMD 8'h00
`define OFF_OPND 8'h04
`define OFF_OFFSET 8'h08
`define OFF_PC 8'h0C
`define OFF_ZPTR 8'h10
`define OFF_STACK 8'h14
`define OFF_STATUS_FLAGS_REG 8'h18
`define OFF_IOVAL 8'h1C
`define OFF_NEXTLEN 8'h20
`define OFF_STATUS 8'h24
`define OFF_RFADDR 8'h28
`define OFF_RFDATA 8'h2C

////////////////////////////////////////////////////////////////////////////////
// Field positions of the operand register.
`define RD_MSB 4
`define RD_LSB 0
`define RR_MSB 9
`define RR_LSB 5
`define IMM_MSB 17
`define IMM_LSB 10
`define BIT_MSB 20
`define BIT_LSB 18

// Bit positions inside the status flag register.
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

////////////////////////////////////////////////////////////////////////////////
// Reset values and bus answers.
`define RST_PC 16'h0000
`define RST_STATUS_FLAGS_REG 8'h00
`define RST_WORD 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// Execution times in clock cycles.
`define CYC_ONE 3'h1
`define CYC_JUMP 3'h2
`define CYC_SKIP_SHORT 3'h2
`define CYC_SKIP_LONG 3'h3
`define CYC_CALL 3'h3
`define CYC_RET 3'h4

////////////////////////////////////////////////////////////////////////////////
// Operation codes.
`define OP_OR_IMM 6'h00
`define OP_XOR_REGS 6'h01
`define OP_MASK_OR_BITS 6'h02
`define OP_MASK_CLEAR_BITS 6'h03
`define OP_SELF_AND_TEST 6'h04
`define OP_SELF_XOR_ZERO 6'h05
`define OP_ADD_ONE 6'h06
`define OP_SUBTRACT_ONE 6'h07
`define OP_RELATIVE_JUMP 6'h08
`define OP_POINTER_JUMP 6'h09
`define OP_RELATIVE_SUB_CALL 6'h0A
`define OP_POINTER_SUB_CALL 6'h0B
`define OP_SUBROUTINE_BACK 6'h0C
`define OP_INTERRUPT_BACK 6'h0D
`define OP_COMPARE_SKIP_EQUAL 6'h0E
`define OP_COMPARE_REGS 6'h0F
`define OP_COMPARE_REGS_CARRY 6'h10
`define OP_COMPARE_IMM 6'h11
`define OP_SKIP_REG_BIT_LOW 6'h12
`define OP_SKIP_REG_BIT_HIGH 6'h13
`define OP_SKIP_IO_BIT_LOW 6'h14
`define OP_SKIP_IO_BIT_HIGH 6'h15
`define OP_BRANCH_FLAG_HIGH 6'h16
`define OP_BRANCH_FLAG_LOW 6'h17
`define OP_BRANCH_SIGNED_GE 6'h18
`define OP_BRANCH_SIGNED_LT 6'h19
`define OP_BRANCH_UNSIGNED_GE 6'h1A
`define OP_BRANCH_UNSIGNED_LT 6'h1B
`define OP_BRANCH_HALF_CARRY 6'h1C
`define OP_BRANCH_NO_HALF_CARRY 6'h1D
`define OP_BRANCH_USER_FLAG 6'h1E
`define OP_BRANCH_NO_USER_FLAG 6'h1F
`define OP_BRANCH_OVERFLOW 6'h20
`define OP_BRANCH_NO_OVERFLOW 6'h21
`define OP_BRANCH_IRQ_ON 6'h22

`endif

/* File: work_regs.v */
`timescale 1ns/1ps
`include "logic_branch_exec_consts.vh"

// Working register file: two registered read ports, one write port.
module work_regs (
  input wire sys_clk,
  input wire [4:0] addr_a,
  input wire [4:0] addr_b,
  input wire we,
  input wire [4:0] waddr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_a,
  output reg [7:0] rdata_b
);

  reg [7:0] mem [0:31];

  // Contents are not reset; software loads the registers it uses.
  always @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[addr_a];
    rdata_b <= mem[addr_b];
  end

endmodule // work_regs

/* File: alu_flags.v */
`timescale 1ns/1ps
`include "logic_branch_exec_consts.vh"

module alu_flags (
  input wire [5:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [7:0] imm,
  input wire [7:0] status_flags_reg_in,
  output reg [7:0] result,
  output reg [7:0] status_flags_reg_out,
  output reg we
);

  reg [8:0] diff;
  reg [7:0] sub;
  reg cin;
  reg logic_op;

  always @*
  begin
    result = a;
    status_flags_reg_out = status_flags_reg_in;
    we = 1'b0;
    logic_op = 1'b1;
    diff = 9'h000;
    sub = (op == `OP_COMPARE_IMM) ? imm : b;
    cin = (op == `OP_COMPARE_REGS_CARRY) ? status_flags_reg_in[`FLAG_C] : 1'b0;
    case (op)
      `OP_OR_IMM: result = a | imm;
      `OP_XOR_REGS: result = a ^ b;
      `OP_MASK_OR_BITS: result = a | imm;
      `OP_MASK_CLEAR_BITS: result = a & (8'hFF - imm);
      `OP_SELF_AND_TEST: result = a & a;
      `OP_SELF_XOR_ZERO: result = a ^ a;
      `OP_ADD_ONE: result = a + 8'h01;
      `OP_SUBTRACT_ONE: result = a - 8'h01;
      default: logic_op = 1'b0;
    endcase
    if (logic_op)
    begin
      // Carry is never touched here; overflow only arises at the sign wrap.
      we = 1'b1;
      status_flags_reg_out[`FLAG_Z] = (result == 8'h00);
      status_flags_reg_out[`FLAG_N] = result[7];
      if (op == `OP_ADD_ONE)
        status_flags_reg_out[`FLAG_V] = (result == 8'h80);
      else if (op == `OP_SUBTRACT_ONE)
        status_flags_reg_out[`FLAG_V] = (result == 8'h7F);
      else
        status_flags_reg_out[`FLAG_V] = 1'b0;
    end
    if ((op == `OP_COMPARE_REGS) || (op == `OP_COMPARE_REGS_CARRY) || (op == `OP_COMPARE_IMM))
    begin
      // The difference is only used for flags; nothing is written back.
      diff = {1'b0, a} - {1'b0, sub} - {8'h00, cin};
      status_flags_reg_out[`FLAG_C] = diff[8];
      status_flags_reg_out[`FLAG_N] = diff[7];
      status_flags_reg_out[`FLAG_V] = (a[7] & ~sub[7] & ~diff[7]) | (~a[7] & sub[7] & diff[7]);
      status_flags_reg_out[`FLAG_H] = (~a[3] & sub[3]) | (sub[3] & diff[3]) | (diff[3] & ~a[3]);
      // With carry the zero flag chains, so multi-byte compares work.
      if (op == `OP_COMPARE_REGS_CARRY)
        status_flags_reg_out[`FLAG_Z] = (diff[7:0] == 8'h00) & status_flags_reg_in[`FLAG_Z];
      else
        status_flags_reg_out[`FLAG_Z] = (diff[7:0] == 8'h00);
    end
  end

endmodule // alu_flags

/* File: logic_branch_exec.v */
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "logic_branch_exec_consts.vh"

module logic_branch_exec (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_EXEC = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [3:0] state_reg;
  reg [5:0] op_reg;
  reg [31:0] opnd_reg;
  reg [11:0] offset_reg;
  reg [15:0] pc_reg;
  reg [15:0] zptr_reg;
  reg [15:0] stack_reg;
  reg [7:0] status_flags_reg_reg;
  reg [7:0] io_val_reg;
  reg next_two_reg;
  reg [4:0] rf_addr_reg;
  reg [2:0] last_cyc_reg;
  reg [2:0] cnt_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire busy;
  wire do_write;
  wire [31:0] wmask;
  wire [7:0] rf_a;
  wire [7:0] rf_b;
  wire [7:0] alu_result;
  wire [7:0] alu_status_flags_reg;
  wire alu_we;
  wire [4:0] rd_idx;
  wire [4:0] rr_idx;
  wire [2:0] bit_idx;
  wire [15:0] rel_target;
  wire rf_we;
  wire [4:0] rf_waddr;
  wire [7:0] rf_wdata;

  assign busy = (state_reg != ST_IDLE);
  assign rd_idx = opnd_reg[`RD_MSB:`RD_LSB];
  assign rr_idx = opnd_reg[`RR_MSB:`RR_LSB];
  assign bit_idx = opnd_reg[`BIT_MSB:`BIT_LSB];
  // Both slots filled and no answer pending: the write takes effect now.
  assign do_write = ~awready & ~wready & ~bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};
  // The relative target is the address after the instruction plus the offset.
  assign rel_target = pc_reg + {{4{offset_reg[11]}}, offset_reg} + 16'h0001;

  // Software only writes the register file while the unit is idle.
  assign rf_we = (state_reg == ST_EXEC) ? alu_we :
                 (do_write && (aw_addr_reg == `OFF_RFDATA) && !busy && w_strb_reg[0]);
  assign rf_waddr = busy ? rd_idx : rf_addr_reg;
  assign rf_wdata = busy ? alu_result : w_data_reg[7:0];

  work_regs u_regs (
    .sys_clk(sys_clk),
    .addr_a(busy ? rd_idx : rf_addr_reg),
    .addr_b(rr_idx),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .rdata_a(rf_a),
    .rdata_b(rf_b)
  );

  alu_flags u_alu (
    .op(op_reg),
    .a(rf_a),
    .b(rf_b),
    .imm(opnd_reg[`IMM_MSB:`IMM_LSB]),
    .status_flags_reg_in(status_flags_reg_reg),
    .result(alu_result),
    .status_flags_reg_out(alu_status_flags_reg),
    .we(alu_we)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Program flow decision for the operation being executed.
  reg [15:0] pc_c;
  reg [2:0] cyc_c;
  reg [7:0] status_flags_reg_c;
  reg push_c;
  reg skip_c;
  reg take_c;

  always @*
  begin
    pc_c = pc_reg + 16'h0001;
    cyc_c = `CYC_ONE;
    status_flags_reg_c = alu_status_flags_reg;
    push_c = 1'b0;
    skip_c = 1'b0;
    take_c = 1'b0;
    case (op_reg)
      `OP_RELATIVE_JUMP:
      begin
        pc_c = rel_target;
        cyc_c = `CYC_JUMP;
      end
      `OP_POINTER_JUMP:
      begin
        pc_c = zptr_reg;
        cyc_c = `CYC_JUMP;
      end
      `OP_RELATIVE_SUB_CALL:
      begin
        pc_c = rel_target;
        cyc_c = `CYC_CALL;
        push_c = 1'b1;
      end
      `OP_POINTER_SUB_CALL:
      begin
        pc_c = zptr_reg;
        cyc_c = `CYC_CALL;
        push_c = 1'b1;
      end
      `OP_SUBROUTINE_BACK:
      begin
        pc_c = stack_reg;
        cyc_c = `CYC_RET;
      end
      `OP_INTERRUPT_BACK:
      begin
        pc_c = stack_reg;
        cyc_c = `CYC_RET;
        status_flags_reg_c[`FLAG_I] = 1'b1;
      end
      `OP_COMPARE_SKIP_EQUAL: skip_c = (rf_a == rf_b);
      `OP_SKIP_REG_BIT_LOW: skip_c = ~rf_b[bit_idx];
      `OP_SKIP_REG_BIT_HIGH: skip_c = rf_b[bit_idx];
      `OP_SKIP_IO_BIT_LOW: skip_c = ~io_val_reg[bit_idx];
      `OP_SKIP_IO_BIT_HIGH: skip_c = io_val_reg[bit_idx];
      `OP_BRANCH_FLAG_HIGH: take_c = status_flags_reg_reg[bit_idx];
      `OP_BRANCH_FLAG_LOW: take_c = ~status_flags_reg_reg[bit_idx];
      `OP_BRANCH_SIGNED_GE: take_c = ~(status_flags_reg_reg[`FLAG_N] ^ status_flags_reg_reg[`FLAG_V]);
      `OP_BRANCH_SIGNED_LT: take_c = status_flags_reg_reg[`FLAG_N] ^ status_flags_reg_reg[`FLAG_V];
      `OP_BRANCH_UNSIGNED_GE: take_c = ~status_flags_reg_reg[`FLAG_C];
      `OP_BRANCH_UNSIGNED_LT: take_c = status_flags_reg_reg[`FLAG_C];
      `OP_BRANCH_HALF_CARRY: take_c = status_flags_reg_reg[`FLAG_H];
      `OP_BRANCH_NO_HALF_CARRY: take_c = ~status_flags_reg_reg[`FLAG_H];
      `OP_BRANCH_USER_FLAG: take_c = status_flags_reg_reg[`FLAG_T];
      `OP_BRANCH_NO_USER_FLAG: take_c = ~status_flags_reg_reg[`FLAG_T];
      `OP_BRANCH_OVERFLOW: take_c = status_flags_reg_reg[`FLAG_V];
      `OP_BRANCH_NO_OVERFLOW: take_c = ~status_flags_reg_reg[`FLAG_V];
      `OP_BRANCH_IRQ_ON: take_c = status_flags_reg_reg[`FLAG_I];
      default: cyc_c = `CYC_ONE;
    endcase
    if (skip_c)
    begin
      // The skipped instruction may be one or two words long.
      if (next_two_reg)
      begin
        pc_c = pc_reg + 16'h0003;
        cyc_c = `CYC_SKIP_LONG;
      end
      else
      begin
        pc_c = pc_reg + 16'h0002;
        cyc_c = `CYC_SKIP_SHORT;
      end
    end
    if (take_c)
    begin
      pc_c = rel_target;
      cyc_c = `CYC_JUMP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and software registers. The execution state owns the program
  // state while busy, so software writes to it are dropped meanwhile.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      op_reg <= 6'h00;
      opnd_reg <= `RST_WORD;
      offset_reg <= 12'h000;
      pc_reg <= `RST_PC;
      zptr_reg <= 16'h0000;
      stack_reg <= 16'h0000;
      status_flags_reg_reg <= `RST_STATUS_FLAGS_REG;
      io_val_reg <= 8'h00;
      next_two_reg <= 1'b0;
      rf_addr_reg <= 5'h00;
      last_cyc_reg <= 3'h0;
      cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (do_write && !busy)
          begin
            case (aw_addr_reg)
              `OFF_CMD:
              begin
                if (w_strb_reg[0])
                begin
                  op_reg <= w_data_reg[5:0];
                  state_reg <= ST_READ;
                end
              end
              `OFF_OPND: opnd_reg <= (opnd_reg & ~wmask) | (w_data_reg & wmask);
              `OFF_OFFSET: offset_reg <= (offset_reg & ~wmask[11:0]) |
                                         (w_data_reg[11:0] & wmask[11:0]);
              `OFF_PC: pc_reg <= (pc_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
              `OFF_ZPTR: zptr_reg <= (zptr_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
              `OFF_STACK: stack_reg <= (stack_reg & ~wmask[15:0]) |
                                       (w_data_reg[15:0] & wmask[15:0]);
              `OFF_STATUS_FLAGS_REG: if (w_strb_reg[0]) status_flags_reg_reg <= w_data_reg[7:0];
              `OFF_IOVAL: if (w_strb_reg[0]) io_val_reg <= w_data_reg[7:0];
              `OFF_NEXTLEN: if (w_strb_reg[0]) next_two_reg <= w_data_reg[0];
              `OFF_RFADDR: if (w_strb_reg[0]) rf_addr_reg <= w_data_reg[4:0];
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
        // Register file data for the operands arrive at the end of this cycle.
        ST_READ: state_reg <= ST_EXEC;
        ST_EXEC:
        begin
          // All effects commit in the first execution cycle; the rest of the
          // documented time is spent busy so software sees the true cost.
          pc_reg <= pc_c;
          status_flags_reg_reg <= status_flags_reg_c;
          if (push_c)
            stack_reg <= pc_reg + 16'h0001;
          last_cyc_reg <= cyc_c;
          cnt_reg <= cyc_c - 3'h1;
          state_reg <= (cyc_c == `CYC_ONE) ? ST_IDLE : ST_HOLD;
        end
        ST_HOLD:
        begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels: address and data are taken independently.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `RST_WORD;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= `OFF_RFDATA) ?
                 `RESP_OKAY : `RESP_DECERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: one read at a time, answered the next cycle.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= `RST_WORD;
      rresp <= `RESP_OKAY;
    end
    else
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (araddr)
          `OFF_CMD: rdata <= {26'h000_0000, op_reg};
          `OFF_OPND: rdata <= opnd_reg;
          `OFF_OFFSET: rdata <= {20'h0_0000, offset_reg};
          `OFF_PC: rdata <= {16'h0000, pc_reg};
          `OFF_ZPTR: rdata <= {16'h0000, zptr_reg};
          `OFF_STACK: rdata <= {16'h0000, stack_reg};
          `OFF_STATUS_FLAGS_REG: rdata <= {24'h00_0000, status_flags_reg_reg};
          `OFF_IOVAL: rdata <= {24'h00_0000, io_val_reg};
          `OFF_NEXTLEN: rdata <= {31'h0000_0000, next_two_reg};
          `OFF_STATUS: rdata <= {28'h000_0000, last_cyc_reg, busy};
          `OFF_RFADDR: rdata <= {27'h000_0000, rf_addr_reg};
          // While busy the port follows the operand, so this reads register rd_idx instead.
          `OFF_RFDATA: rdata <= {24'h00_0000, rf_a};
          default:
          begin
            rdata <= `RST_WORD;
            rresp <= `RESP_DECERR;
          end
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // logic_branch_exec

/* File: exec_bus_sva.sv */
`timescale 1ns/1ps

module exec_bus_checker (
  input logic sys_clk,
  input logic rst_b,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  input logic rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] ra_reg;

  // Remembers which register the read in flight targets.
  always @(posedge sys_clk)
    if (!rst_b)
      ra_reg <= 8'h00;
    else if (arvalid && arready)
      ra_reg <= araddr;

  ////////////////////////////////////////////////////////////////////////////
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  property p_r_lat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_w_lat;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write answer late");
  property p_unmapped;
    arvalid && arready && araddr > 8'h2C |=> rresp == 2'h3 && rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_aw_closed;
    !awready && !(bvalid && bready) |=> !awready;
  endproperty
  a_aw_closed: assert property (p_aw_closed) else $error("address slot reopened");
  property p_b_slots;
    $rose(bvalid) |-> !awready && !wready;
  endproperty
  a_b_slots: assert property (p_b_slots) else $error("slots open with answer");
  property p_status;
    rvalid && ra_reg == 8'h24 |-> rdata[31:4] == 28'h000_0000 && rdata[3:1] <= 3'h4;
  endproperty
  a_status: assert property (p_status) else $error("cycle count out of range");
  property p_pc16;
    rvalid && ra_reg == 8'h0C |-> rdata[31:16] == 16'h0000;
  endproperty
  a_pc16: assert property (p_pc16) else $error("program counter too wide");
  c_decerr: cover property (bvalid && bresp == 2'h3);
  c_rdecerr: cover property (rvalid && rresp == 2'h3);
  c_ret: cover property (rvalid && ra_reg == 8'h24 && rdata[3:1] == 3'h4);
endmodule // exec_bus_checker

/* File: instr_src.sv */
`timescale 1ns/1ps

// Program store: slot i holds operation i up to 6'h22; every slot above that holds an undefined code.
module instr_src (
  input logic [5:0] idx,
  output logic [5:0] op
);
  assign op = (idx > 6'h22) ? 6'h3F : idx;
endmodule // instr_src

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "logic_branch_exec_consts.vh"

module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0;
  int checks_done = 0;
  int seed = 94048;
  logic [15:0] pc, zp, st, epc, est;
  logic [7:0] sr, esr, a, b, ea, imm, io;
  logic [4:0] rdi;
  logic [2:0] bt, ecy;
  logic [11:0] k;
  logic nl;
  logic [5:0] idx = 6'h00;
  logic [5:0] op;

  always #10 sys_clk = ~sys_clk;

  logic_branch_exec DUT (.sys_clk(sys_clk), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  instr_src prog (.idx(idx), .op(op));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic bad;
    n_errors++;
    finish_test;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // The leading edge keeps a new request off the edge where the last one was released.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic aw_p, w_p, b_p;
    @(posedge sys_clk);
    bq.push_back(er);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    // Pending flags are kept locally: the strobes still read their old value in this step.
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while ((aw_p || w_p || b_p) && n < 50)
    begin
      @(posedge sys_clk);
      if (aw_p && awready) awvalid <= 1'b0;
      aw_p = aw_p && !awready;
      if (w_p && wready) wvalid <= 1'b0;
      w_p = w_p && !wready;
      if (b_p && bvalid) bready <= 1'b0;
      b_p = b_p && !bvalid;
      n++;
    end
    if (n >= 50) bad();
  endtask

  // A zero mask marks a poll whose answer is only steered on, not compared.
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
    output logic [31:0] q, input logic [1:0] er = 2'h0);
    int n;
    logic ar_p, r_p;
    @(posedge sys_clk);
    rq.push_back({er, m, e});
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    q = 32'h0000_0000;
    ar_p = 1'b1;
    r_p = 1'b1;
    while ((ar_p || r_p) && n < 50)
    begin
      @(posedge sys_clk);
      if (ar_p && arready) arvalid <= 1'b0;
      ar_p = ar_p && !arready;
      if (r_p && rvalid) rready <= 1'b0;
      if (r_p && rvalid) q = rdata;
      r_p = r_p && !rvalid;
      n++;
    end
    if (n >= 50) bad();
  endtask

  always @(posedge sys_clk)
  begin
    if (rvalid && rready && rq.size() > 0 && rq[0][63:32] != 32'h0000_0000)
    begin
      chk(rdata & rq[0][63:32], rq[0][31:0]);
      chk({30'h0, rresp}, {30'h0, rq[0][65:64]});
    end
    if (rvalid && rready && rq.size() > 0) void'(rq.pop_front());
    if (bvalid && bready && bq.size() > 0)
      chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic model;
    logic [7:0] r, bb;
    logic [8:0] d;
    logic t;
    r = a;
    esr = sr;
    est = st;
    ecy = 3'h1;
    epc = pc + 16'h0001;
    t = 1'b0;
    bb = (op == `OP_COMPARE_IMM) ? imm : b;
    d = {1'b0, a} - {1'b0, bb} - {8'h00, (op == `OP_COMPARE_REGS_CARRY) && sr[0]};
    case (op)
      6'h00, 6'h02: r = a | imm;
      6'h01: r = a ^ b;
      6'h03: r = a & (8'hFF - imm);
      6'h05: r = 8'h00;
      6'h06: r = a + 8'h01;
      6'h07: r = a - 8'h01;
      6'h08, 6'h0A: epc = pc + {{4{k[11]}}, k} + 16'h0001;
      6'h09, 6'h0B: epc = zp;
      6'h0C, 6'h0D: epc = st;
      6'h0E: t = (a == b);
      6'h12, 6'h13: t = b[bt] ^ !op[0];
      6'h14, 6'h15: t = io[bt] ^ !op[0];
      6'h16, 6'h17: t = sr[bt] ^ op[0];
      6'h18, 6'h19: t = sr[2] ^ sr[3] ^ !op[0];
      6'h1A, 6'h1B: t = sr[0] ^ !op[0];
      6'h1C, 6'h1D: t = sr[5] ^ op[0];
      6'h1E, 6'h1F: t = sr[6] ^ op[0];
      6'h20, 6'h21: t = sr[3] ^ op[0];
      6'h22: t = sr[7];
      default: ;
    endcase
    if (op <= 6'h07)
      esr[3:1] = {(op == 6'h06) ? r == 8'h80 : (op == 6'h07) && r == 8'h7F, r[7], r == 8'h00};
    if (op >= 6'h0F && op <= 6'h11)
      esr[5:0] = {~a[3] & bb[3] | bb[3] & d[3] | d[3] & ~a[3], sr[4],
        a[7] & ~bb[7] & ~d[7] | ~a[7] & bb[7] & d[7], d[7],
        (d[7:0] == 8'h00) && (op != 6'h10 || sr[1]), d[8]};
    if (op >= 6'h08 && op <= 6'h0D) ecy = {1'b0, op[2:1]} + 3'h2;
    if (op == 6'h0A || op == 6'h0B) est = pc + 16'h0001;
    if (op == 6'h0D) esr[7] = 1'b1;
    if (t && op <= 6'h15) epc = pc + 16'h0002 + {15'h0, nl};
    if (t && op <= 6'h15) ecy = 3'h2 + {2'h0, nl};
    if (t && op >= 6'h16) epc = pc + {{4{k[11]}}, k} + 16'h0001;
    if (t && op >= 6'h16) ecy = 3'h2;
    ea = r;
  endtask

  task automatic run_one;
    int n;
    {a, b, imm, sr, io, bt, nl, k, rdi} = 61'({$random(seed), $random(seed)});
    {pc, zp, st} = 48'({$random(seed), $random(seed)});
    // Half the compare-skip cases need equal operands to take the skip.
    if (imm[0]) b = a;
    wr(`OFF_PC, {16'h0000, pc});
    wr(`OFF_STATUS_FLAGS_REG, {24'h00_0000, sr});
    wr(`OFF_ZPTR, {16'h0000, zp});
    wr(`OFF_STACK, {16'h0000, st});
    wr(`OFF_IOVAL, {24'h00_0000, io});
    wr(`OFF_NEXTLEN, {31'h0, nl});
    wr(`OFF_OFFSET, {20'h0_0000, k});
    wr(`OFF_OPND, {11'h000, bt, imm, rdi ^ 5'h01, rdi});
    wr(`OFF_RFADDR, {27'h0, rdi});
    wr(`OFF_RFDATA, {24'h00_0000, a});
    wr(`OFF_RFADDR, {27'h0, rdi ^ 5'h01});
    wr(`OFF_RFDATA, {24'h00_0000, b});
    model();
    wr(`OFF_CMD, {26'h0, op});
    n = 0;
    v = 32'h0000_0001;
    while (v[0] && n < 20)
    begin
      rd(`OFF_STATUS, 32'h0000_0000, 32'h0000_0000, v);
      n++;
    end
    if (v[0]) bad();
    rd(`OFF_PC, 32'hFFFF_FFFF, {16'h0000, epc}, v);
    rd(`OFF_STATUS_FLAGS_REG, 32'hFFFF_FFFF, {24'h00_0000, esr}, v);
    rd(`OFF_STACK, 32'hFFFF_FFFF, {16'h0000, est}, v);
    rd(`OFF_STATUS, 32'hFFFF_FFFF, {28'h0, ecy, 1'b0}, v);
    wr(`OFF_RFADDR, {27'h0, rdi});
    rd(`OFF_RFDATA, 32'hFFFF_FFFF, {24'h00_0000, ea}, v);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h30, 32'hFFFF_FFFF, 32'h0000_0000, v, 2'h3);
    wr(8'h30, 32'h0000_0000, 2'h3);
    repeat (3)
      for (int i = 0; i < 36; i++)
      begin
        idx <= i[5:0];
        run_one();
      end
    finish_test();
  end
endmodule // tb_top

bind logic_branch_exec exec_bus_checker chk_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
